// File: hw/vk_keyer.sv
// luminance/linear/additive keyer datapath with avalon-mm control registers
`timescale 1ns/100ps
`default_nettype none
`include "vk_params.svh"
module vk_keyer (
    input  wire logic             clk,              // pixel clock
    input  wire logic             sys_rst,          // async reset
    input  wire vk_pkg::vk_vin_t  vid_in,           // pixel stream in
    output var  vk_pkg::vk_vout_t vid_out,          // composite and key preview
    input  wire logic [5:0]       avs_address,      // byte address
    input  wire logic             avs_read,         // read request
    input  wire logic             avs_write,        // write request
    input  wire logic [31:0]      avs_writedata,    // write data
    input  wire logic [3:0]       avs_byteenable,   // byte lanes
    output var  logic [31:0]      avs_readdata,     // read data
    output logic                  avs_waitrequest   // stall
);
    import vk_pkg::*;

    default clocking vk_cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    localparam vk_cfg_t CFG_RST = {`VK_CTRL_RST, `VK_UPPER_RST, `VK_LOWER_RST,
        `VK_OPAC_RST, `VK_POS_RST, `VK_SIZE_RST, `VK_CORE_RST};

    vk_cfg_t     sh;
    vk_cfg_t     act;
    logic [20:0] sh_recip;
    logic [20:0] act_recip;
    logic        ack;
    logic        wen;
    logic        thr_wr;
    logic [9:0]  wd;
    logic [9:0]  span;
    logic [10:0] csum;
    logic [9:0]  clip_rd;
    logic [6:0]  gp;
    logic [17:0] gprod;
    logic [9:0]  gspan;
    logic [15:0] rmux;
    logic        busy;
    logic        latch;
    vk_dv_t      dv;
    logic        dv_go;
    logic [4:0]  cnt;
    logic [10:0] rem;
    logic [10:0] dr;
    logic        qb;
    logic [10:0] nrem;
    logic [20:0] q;
    logic [9:0]  den;

    function automatic logic [19:0] vk_place(input logic [9:0] c, input logic [9:0] sp);
        logic [9:0] h;
        logic [9:0] lo;
        h = {1'b0, sp[9:1]};
        lo = (c < h) ? 10'h000 : c - h;
        if (lo > `VK_KMAX - sp) begin
            lo = `VK_KMAX - sp;
        end
        vk_place = {lo + sp, lo};
    endfunction

    // bus slave: one wait cycle, then the answer
    assign avs_waitrequest = (avs_read | avs_write) & ~ack;
    assign wen = avs_write & ack & (&avs_byteenable[1:0]);
    assign wd = avs_writedata[9:0];
    assign thr_wr = wen & ((avs_address == `VK_A_CLIP) | (avs_address == `VK_A_GAIN)
                    | (avs_address == `VK_A_UPPER) | (avs_address == `VK_A_LOWER));
    assign span = sh.upper - sh.lower;
    assign csum = {1'b0, sh.upper} + {1'b0, sh.lower};
    assign clip_rd = csum[10:1];
    assign gp = ((|avs_writedata[15:7]) || (wd[6:0] > `VK_GAIN_MAX)) ? `VK_GAIN_MAX : wd[6:0];
    assign gprod = {11'h000, gp} * `VK_GAIN_K;
    assign gspan = gprod[17:8];

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack <= 1'b0;
        end else begin
            ack <= (avs_read | avs_write) & ~ack;
        end
    end

    always_comb begin
        rmux = 16'h0000;
        case (avs_address)
            `VK_A_CTRL:  rmux = {7'h00, sh.ctl};
            `VK_A_CLIP:  rmux = {6'h00, clip_rd};
            `VK_A_GAIN:  rmux = {6'h00, span};
            `VK_A_UPPER: rmux = {6'h00, sh.upper};
            `VK_A_LOWER: rmux = {6'h00, sh.lower};
            `VK_A_OPAC:  rmux = {6'h00, sh.opac};
            `VK_A_POS:   rmux = {13'h0000, sh.pos};
            `VK_A_SIZE:  rmux = {14'h0000, sh.size};
            `VK_A_CORE:  rmux = {6'h00, sh.core};
            `VK_A_STAT:  rmux = {14'h0000, (sh != act) | (sh_recip != act_recip), busy};
            default:     rmux = 16'h0000;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read & ~ack) begin
            avs_readdata <= {16'h0000, rmux};
        end
    end

    // shadow settings; thresholds kept consistent on every write
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sh <= CFG_RST;
        end else if (wen) begin
            case (avs_address)
                `VK_A_CTRL: begin
                    if (wd[1:0] != 2'b11) begin
                        sh.ctl <= vk_ctl_t'(wd[8:0]);
                    end
                end
                `VK_A_CLIP:  {sh.upper, sh.lower} <= vk_place(wd, span);
                `VK_A_GAIN:  {sh.upper, sh.lower} <= vk_place(clip_rd, gspan);
                `VK_A_UPPER: sh.upper <= (wd < sh.lower) ? sh.lower : wd;
                `VK_A_LOWER: sh.lower <= (wd > sh.upper) ? sh.upper : wd;
                `VK_A_OPAC:  sh.opac <= wd;
                `VK_A_POS:   sh.pos <= wd[2:0];
                `VK_A_SIZE:  sh.size <= wd[1:0];
                `VK_A_CORE:  sh.core <= wd;
                default: ;
            endcase
        end
    end

    clip_move_a: assert property (wen && avs_address == `VK_A_CLIP |=>
        (sh.upper - sh.lower) == $past(sh.upper - sh.lower))
        else $error("clip write changed the span");
    gain_span_a: assert property (wen && avs_address == `VK_A_GAIN |=>
        (sh.upper - sh.lower) == $past(gspan))
        else $error("gain write gave wrong threshold spacing");
    pair_fix_a: assert property (wen && avs_address == `VK_A_UPPER |=>
        $stable(sh.lower))
        else $error("upper write moved lower threshold");

    // reciprocal of span by serial division, so the ramp needs no divider
    assign dr = {rem[9:0], cnt == `VK_DIV_LAST};
    assign qb = dr >= {1'b0, den};
    assign nrem = qb ? dr - {1'b0, den} : dr;
    assign busy = dv_go | (dv == VK_RUN);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dv_go <= 1'b0;
            dv <= VK_IDLE;
            cnt <= 5'h00;
            rem <= 11'h000;
            q <= 21'h000000;
            den <= 10'h000;
            sh_recip <= `VK_RECIP_RST;
        end else begin
            dv_go <= thr_wr;
            if (dv_go) begin
                dv <= VK_RUN;
                cnt <= `VK_DIV_LAST;
                rem <= 11'h000;
                q <= 21'h000000;
                den <= span;
            end else begin
                unique case (dv)
                    VK_IDLE: ;
                    VK_RUN: begin
                        rem <= nrem;
                        q <= {q[19:0], qb};
                        cnt <= cnt - 5'h01;
                        if (cnt == 5'h00) begin
                            dv <= VK_IDLE;
                            sh_recip <= {q[19:0], qb};
                        end
                    end
                endcase
            end
        end
    end

    // settings move to the datapath only at frame start; a busy divider defers it
    assign latch = vid_in.valid & vid_in.sof & ~busy;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            act <= CFG_RST;
            act_recip <= `VK_RECIP_RST;
        end else if (latch) begin
            act <= sh;
            act_recip <= sh_recip;
        end
    end

    frame_hold_a: assert property (!$stable(act) |-> $past(latch))
        else $error("settings changed inside a frame");

    // datapath
    vk_side_t    sd [0:9];
    logic [9:0]  dl [0:9];
    logic [3:0]  tap;
    logic [9:0]  nc;
    logic [30:0] rprod;
    logic [9:0]  next_ka;
    logic [9:0]  ka;
    logic [9:0]  kb;
    logic [9:0]  k2;
    logic [19:0] k2p;
    logic [19:0] k3p;
    logic [11:0] sv;
    logic [9:0]  next_ks;
    logic [9:0]  ks;
    logic [9:0]  ki;
    logic        mk;
    logic [20:0] opp;
    logic [9:0]  kf;
    logic [10:0] kk;
    logic [9:0]  fc;
    logic [20:0] bgp;
    logic [20:0] flp;
    logic [9:0]  kfm;
    logic        mv;
    logic        ms;
    logic [21:0] sum;

    // cut, background and fill enter together; the cut (the fill when self_key is set) gets its own tapped line
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < 10; i++) begin
                sd[i] <= '0;
                dl[i] <= 10'h000;
            end
        end else begin
            sd[0] <= {vid_in.valid, vid_in.sof, vid_in.bg, vid_in.fill,
                      vid_in.mask, vid_in.mpat};
            dl[0] <= act.ctl.self_key ? vid_in.fill : vid_in.cut;
            for (int i = 1; i < 10; i++) begin
                sd[i] <= sd[i-1];
                dl[i] <= dl[i-1];
            end
        end
    end

    // centre tap dl[5] lines up with sd[5]; pos moves it by -4..+3 pixels
    assign tap = `VK_CTR_BASE + {act.pos[2], act.pos};

    always_comb begin
        nc = dl[tap + 4'h1];
        if ((act.size != 2'h0) && (dl[tap + 4'h2] < nc)) begin
            nc = dl[tap + 4'h2];
        end
        if (act.size[1] && (dl[tap] < nc)) begin
            nc = dl[tap];
        end
        rprod = {21'h000000, nc - act.lower} * {10'h000, act_recip};
        // equal thresholds fall through to a hard edge
        if (nc >= act.upper) begin
            next_ka = `VK_KMAX;
        end else if (nc <= act.lower) begin
            next_ka = 10'h000;
        end else begin
            next_ka = rprod[19:10];
        end
    end

    assign k2p = {10'h000, ka} * {10'h000, ka};
    assign k3p = {10'h000, k2} * {10'h000, kb};
    assign sv = {2'b00, k2} + {1'b0, k2, 1'b0} - {1'b0, k3p[19:10], 1'b0};

    always_comb begin
        next_ks = kb;
        if (act.ctl.s_shape && (act.ctl.mode == VK_LUMA)) begin
            next_ks = (sv > 12'h3ff) ? `VK_KMAX : sv[9:0];
        end
    end

    always_comb begin
        ki = act.ctl.invert ? `VK_KMAX - ks : ks;
        mk = act.ctl.mask_vid ? (sd[8].mask >= `VK_MASK_TH) : sd[8].mpat;
        // inhibit wins where both masks cover a pixel
        if (act.ctl.inhibit_en && mk) begin
            ki = 10'h000;
        end else if (act.ctl.force_en && mk) begin
            ki = `VK_KMAX;
        end
        opp = {11'h000, ki} * {10'h000, {1'b0, act.opac} + 11'h001};
    end

    // full key reaches 1024 so opaque areas drop the background entirely
    assign kk = {1'b0, kf} + {10'h000, kf[9]};
    assign fc = (act.ctl.coring && (kf == 10'h000) && (sd[9].fill < act.core))
                ? 10'h000 : sd[9].fill;
    assign sum = {1'b0, bgp} + {1'b0, flp};

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ka <= 10'h000;
            kb <= 10'h000;
            k2 <= 10'h000;
            ks <= 10'h000;
            kf <= 10'h000;
        end else begin
            ka <= next_ka;
            kb <= ka;
            k2 <= k2p[19:10];
            ks <= next_ks;
            kf <= opp[19:10];
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bgp <= 21'h000000;
            flp <= 21'h000000;
            kfm <= 10'h000;
            mv <= 1'b0;
            ms <= 1'b0;
        end else begin
            bgp <= {11'h000, sd[9].bg} * {10'h000, 11'h400 - kk};
            if (act.ctl.mode == VK_ADD) begin
                flp <= {1'b0, fc, 10'h000};
            end else begin
                flp <= {11'h000, fc} * {10'h000, kk};
            end
            kfm <= kf;
            mv <= sd[9].valid;
            ms <= sd[9].sof;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            vid_out <= '0;
        end else begin
            vid_out.valid <= mv;
            vid_out.sof <= ms;
            vid_out.y <= (sum[21:20] != 2'b00) ? `VK_KMAX : sum[19:10];
            vid_out.preview <= kfm;
        end
    end

    latency_a: assert property (vid_out.valid == $past(vid_in.valid, 12))
        else $error("output valid not aligned to input");
    hard_edge_a: assert property (act.upper == act.lower |=>
        (ka == 10'h000) || (ka == `VK_KMAX))
        else $error("zero gain produced a soft key");
    no_scurve_a: assert property (act.ctl.mode == VK_LIN |=> ks == $past(kb))
        else $error("linear key was s-shaped");
    invert_a: assert property (act.ctl.invert && !act.ctl.inhibit_en
        && !act.ctl.force_en && act.opac == `VK_KMAX |=> kf == `VK_KMAX - $past(ks))
        else $error("inverted key wrong");
    inhibit_a: assert property (act.ctl.inhibit_en && mk |=> kf == 10'h000)
        else $error("inhibit mask did not block the key");
    add_fill_a: assert property (act.ctl.mode == VK_ADD && kf == `VK_KMAX
        |-> ##2 vid_out.y == $past(sd[9].fill, 2))
        else $error("opaque additive pixel is not the fill");
    mul_clear_a: assert property (act.ctl.mode != VK_ADD && kf == 10'h000
        |-> ##2 vid_out.y == $past(sd[9].bg, 2))
        else $error("transparent pixel is not the background");
    preview_a: assert property (vid_out.preview == $past(kf, 2))
        else $error("preview does not follow the key");

    frame_cov: cover property (latch && (sh != act));
    soft_cov: cover property (kf != 10'h000 && kf != `VK_KMAX && act.ctl.mode == VK_LUMA);
    div_cov: cover property (dv == VK_RUN && cnt == 5'h00);
    self_cov: cover property (act.ctl.self_key && act.ctl.mode != VK_ADD);
endmodule
`default_nettype wire

// File: hw/vk_params.svh
// register map, reset values and fixed levels of the video keyer
`ifndef VK_PARAMS_SVH
`define VK_PARAMS_SVH
`define VK_A_CTRL    6'h00
`define VK_A_CLIP    6'h04
`define VK_A_GAIN    6'h08
`define VK_A_UPPER   6'h0c
`define VK_A_LOWER   6'h10
`define VK_A_OPAC    6'h14
`define VK_A_POS     6'h18
`define VK_A_SIZE    6'h1c
`define VK_A_CORE    6'h20
`define VK_A_STAT    6'h24
`define VK_CTRL_RST  9'h001
`define VK_UPPER_RST 10'h3ff
`define VK_LOWER_RST 10'h000
`define VK_OPAC_RST  10'h3ff
`define VK_POS_RST   3'h0
`define VK_SIZE_RST  2'h0
`define VK_CORE_RST  10'h000
`define VK_RECIP_RST 21'h000401
`define VK_KMAX      10'h3ff
`define VK_GAIN_K    18'h00a3b
`define VK_GAIN_MAX  7'h64
`define VK_MASK_TH   10'h200
`define VK_DIV_LAST  5'h14
`define VK_CTR_BASE  4'h4
`endif

// File: hw/vk_pkg.sv
// types shared by the video keyer
package vk_pkg;
    typedef enum logic [1:0] {VK_ADD = 2'b00, VK_LUMA = 2'b01, VK_LIN = 2'b10} vk_mode_t;
    typedef enum logic {VK_IDLE = 1'b0, VK_RUN = 1'b1} vk_dv_t;
    typedef struct packed {
        logic     self_key;
        logic     coring;
        logic     mask_vid;
        logic     force_en;
        logic     inhibit_en;
        logic     invert;
        logic     s_shape;
        vk_mode_t mode;
    } vk_ctl_t;
    typedef struct packed {
        vk_ctl_t    ctl;
        logic [9:0] upper;
        logic [9:0] lower;
        logic [9:0] opac;
        logic [2:0] pos;
        logic [1:0] size;
        logic [9:0] core;
    } vk_cfg_t;
    typedef struct packed {
        logic       valid;
        logic       sof;
        logic [9:0] bg;
        logic [9:0] cut;
        logic [9:0] fill;
        logic [9:0] mask;
        logic       mpat;
    } vk_vin_t;
    typedef struct packed {
        logic       valid;
        logic       sof;
        logic [9:0] bg;
        logic [9:0] fill;
        logic [9:0] mask;
        logic       mpat;
    } vk_side_t;
    typedef struct packed {
        logic       valid;
        logic       sof;
        logic [9:0] y;
        logic [9:0] preview;
    } vk_vout_t;
endpackage

// File: testbench/video_keyer_control_mixer_tb.sv
// self-checking bench for the video keyer
`timescale 1ns/100ps
`default_nettype none
`include "vk_params.svh"
module video_keyer_control_mixer_tb;
    import vk_pkg::*;
    localparam int LAT = 12;
    typedef struct {logic c; logic s; logic [9:0] y; logic [9:0] p; int t;} vk_exp_t;
    logic        clk            = 1'b0;
    logic        sys_rst        = 1'b1;
    vk_vin_t     vid_in;
    vk_vout_t    vid_out;
    logic [5:0]  avs_address    = 6'h00;
    logic        avs_read       = 1'b0;
    logic        avs_write      = 1'b0;
    logic [31:0] avs_writedata  = 32'h0;
    logic [3:0]  avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    int          num_errors     = 0;
    int          cmp_count      = 0;
    int          cyc            = 0;
    logic [31:0] rnd            = 32'h8dfbf87f;
    logic [31:0] q;
    vk_exp_t     exp_q[$];
    vk_exp_t     e;
    logic [5:0]  ra [10] = '{`VK_A_CTRL, `VK_A_UPPER, `VK_A_LOWER, `VK_A_OPAC, `VK_A_POS,
                             `VK_A_SIZE, `VK_A_CORE, `VK_A_CLIP, `VK_A_GAIN, 6'h28};
    logic [31:0] rv [10] = '{`VK_CTRL_RST, `VK_UPPER_RST, `VK_LOWER_RST, `VK_OPAC_RST,
                             `VK_POS_RST, `VK_SIZE_RST, `VK_CORE_RST, 32'h1ff, 32'h3ff, 32'h0};

    always #4 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    vk_src_model i_src (.clk(clk), .vid(vid_in));

    vk_keyer i_dut (
        .clk            (clk),
        .sys_rst        (sys_rst),
        .vid_in         (vid_in),
        .vid_out        (vid_out),
        .avs_address    (avs_address),
        .avs_read       (avs_read),
        .avs_write      (avs_write),
        .avs_writedata  (avs_writedata),
        .avs_byteenable (avs_byteenable),
        .avs_readdata   (avs_readdata),
        .avs_waitrequest(avs_waitrequest)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] want);
        cmp_count++;
        if (seen !== want) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, want, seen);
        end
    endtask

    task automatic end_sim();
        if (num_errors == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // request held until waitrequest is sampled low, then released
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        int n;
        n = 0;
        avs_address <= a;
        avs_write <= w;
        avs_read <= ~w;
        avs_writedata <= d;
        avs_byteenable <= be;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            chk("bus wait", 0, 1);
            end_sim();
        end
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask

    // write, then wait for the threshold divider so the next frame takes it
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        int n;
        bus(1'b1, a, d, 4'hf);
        n = 0;
        do begin
            bus(1'b0, `VK_A_STAT, 32'h0, 4'hf);
            n++;
        end while (q[0] !== 1'b0 && n < 60);
        if (q[0] !== 1'b0) begin
            chk("busy wait", 0, 1);
            end_sim();
        end
    endtask

    task automatic rd(input string nm, input logic [5:0] a, input logic [31:0] want);
        bus(1'b0, a, 32'h0, 4'hf);
        chk(nm, q, want);
    endtask

    task automatic px(input logic s, input logic [9:0] b, c, f, m, input logic mp,
                      input logic ck, input logic [9:0] y, p);
        exp_q.push_back('{ck, s, y, p, cyc});
        i_src.send(s, b, c, f, m, mp);
    endtask

    // frame start pixel; settings swap on it, so only its timing is judged
    task automatic sof();
        px(1'b1, 10'h0, 10'h0, 10'h0, 10'h0, 1'b0, 1'b0, 10'h0, 10'h0);
    endtask

    // pixel whose key is expected fully on or fully off
    task automatic kx(input logic [9:0] c, f, m, input logic mp, input logic on, input logic add);
        logic [10:0] s;
        rnd = lfsr(rnd);
        s = {1'b0, rnd[9:0]} + {1'b0, f};
        if (on) px(1'b0, rnd[9:0], c, f, m, mp, 1'b1, f, 10'h3ff);
        else if (add) px(1'b0, rnd[9:0], c, f, m, mp, 1'b1, s[10] ? 10'h3ff : s[9:0], 10'h0);
        else px(1'b0, rnd[9:0], c, f, m, mp, 1'b1, rnd[9:0], 10'h0);
    endtask

    // output side: oldest note against each pixel that appears
    always @(posedge clk) begin
        if (vid_out.valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk("spare pixel", 0, 1);
            end else begin
                e = exp_q.pop_front();
                chk("latency", cyc - e.t, LAT + 1);
                chk("sof", vid_out.sof, e.s);
                if (e.c) begin
                    chk("y", vid_out.y, e.y);
                    chk("preview", vid_out.preview, e.p);
                end
            end
        end
    end

    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 10; i++) rd("reset value", ra[i], rv[i]);
        for (int m = 0; m < 3; m++) begin
            wr(`VK_A_CTRL, {29'h0, m == 1, m[1:0]});
            sof();
            for (int i = 0; i < 4; i++) begin
                rnd = lfsr(rnd);
                kx(i[0] ? 10'h3ff : 10'h0, rnd[19:10], 10'h0, 1'b0, i[0], m == 0);
            end
            i_src.idle();
        end
        sof();
        kx(10'h3ff, 10'h155, 10'h0, 1'b0, 1'b1, 1'b0);
        i_src.idle();
        wr(`VK_A_CTRL, 32'h00a);
        kx(10'h3ff, 10'h2aa, 10'h0, 1'b0, 1'b1, 1'b0);
        i_src.idle();
        sof();
        kx(10'h3ff, 10'h123, 10'h0, 1'b0, 1'b0, 1'b0);
        kx(10'h0, 10'h321, 10'h0, 1'b0, 1'b1, 1'b0);
        i_src.idle();
        wr(`VK_A_CTRL, 32'h011);
        sof();
        kx(10'h3ff, 10'h111, 10'h0, 1'b1, 1'b0, 1'b0);
        kx(10'h3ff, 10'h222, 10'h0, 1'b0, 1'b1, 1'b0);
        i_src.idle();
        wr(`VK_A_CTRL, 32'h061);
        sof();
        kx(10'h0, 10'h333, 10'h200, 1'b0, 1'b1, 1'b0);
        kx(10'h0, 10'h0aa, 10'h1ff, 1'b1, 1'b0, 1'b0);
        i_src.idle();
        wr(`VK_A_CTRL, 32'h001);
        wr(`VK_A_OPAC, 32'h0);
        sof();
        kx(10'h3ff, 10'h2bc, 10'h0, 1'b0, 1'b0, 1'b0);
        i_src.idle();
        wr(`VK_A_OPAC, 32'h3ff);
        wr(`VK_A_CTRL, 32'h101);
        sof();
        kx(10'h0, 10'h3ff, 10'h0, 1'b0, 1'b1, 1'b0);
        kx(10'h3ff, 10'h0, 10'h0, 1'b0, 1'b0, 1'b0);
        i_src.idle();
        wr(`VK_A_CTRL, 32'h080);
        wr(`VK_A_CORE, 32'h100);
        sof();
        kx(10'h0, 10'h0ff, 10'h0, 1'b0, 1'b0, 1'b0);
        kx(10'h0, 10'h100, 10'h0, 1'b0, 1'b0, 1'b1);
        i_src.idle();
        wr(`VK_A_CORE, 32'h0);
        wr(`VK_A_CTRL, 32'h001);
        wr(`VK_A_SIZE, 32'h1);
        sof();
        // a lone opaque pixel must vanish when narrowed
        for (int i = 0; i < 5; i++) kx(i == 2 ? 10'h3ff : 10'h0, 10'h1a5, 10'h0, 1'b0, 1'b0, 1'b0);
        i_src.idle();
        wr(`VK_A_SIZE, 32'h0);
        // cut shifted one pixel late: each pixel keys on its predecessor's cut
        wr(`VK_A_POS, 32'h1);
        sof();
        kx(10'h3ff, 10'h0c3, 10'h0, 1'b0, 1'b0, 1'b0);
        kx(10'h0, 10'h0c4, 10'h0, 1'b0, 1'b1, 1'b0);
        i_src.idle();
        wr(`VK_A_POS, 32'h0);
        wr(`VK_A_CTRL, 32'h003);
        rd("ctrl refused mode", `VK_A_CTRL, 32'h001);
        bus(1'b1, `VK_A_CTRL, 32'h002, 4'h1);
        rd("ctrl partial lanes", `VK_A_CTRL, 32'h001);
        wr(6'h28, 32'hffff);
        rd("unmapped", 6'h28, 32'h0);
        wr(`VK_A_LOWER, 32'h100);
        wr(`VK_A_UPPER, 32'h200);
        rd("clip", `VK_A_CLIP, 32'h180);
        rd("gain", `VK_A_GAIN, 32'h100);
        sof();
        kx(10'h200, 10'h0f0, 10'h0, 1'b0, 1'b1, 1'b0);
        kx(10'h100, 10'h0f1, 10'h0, 1'b0, 1'b0, 1'b0);
        kx(10'h2ff, 10'h0f2, 10'h0, 1'b0, 1'b1, 1'b0);
        kx(10'h0ff, 10'h0f3, 10'h0, 1'b0, 1'b0, 1'b0);
        // cut half way between the thresholds gives a half key
        px(1'b0, 10'h0, 10'h180, 10'h3ff, 10'h0, 1'b0, 1'b1, 10'h200, 10'h200);
        i_src.idle();
        // linear key with s-shape asked for must stay a straight ramp
        wr(`VK_A_CTRL, 32'h006);
        sof();
        px(1'b0, 10'h0, 10'h140, 10'h3ff, 10'h0, 1'b0, 1'b1, 10'h0ff, 10'h100);
        i_src.idle();
        wr(`VK_A_CTRL, 32'h001);
        wr(`VK_A_GAIN, 32'h0);
        rd("gain zero", `VK_A_GAIN, 32'h0);
        sof();
        kx(10'h181, 10'h0f4, 10'h0, 1'b0, 1'b1, 1'b0);
        kx(10'h17f, 10'h0f5, 10'h0, 1'b0, 1'b0, 1'b0);
        i_src.idle();
        wr(`VK_A_GAIN, 32'd50);
        rd("gain half", `VK_A_GAIN, 32'h1ff);
        wr(`VK_A_CLIP, 32'h200);
        rd("gain after clip", `VK_A_GAIN, 32'h1ff);
        wr(`VK_A_LOWER, 32'h080);
        wr(`VK_A_UPPER, 32'h300);
        rd("lower kept", `VK_A_LOWER, 32'h080);
        rd("gain follows", `VK_A_GAIN, 32'h280);
        rd("clip follows", `VK_A_CLIP, 32'h1c0);
        for (int n = 0; n < 40 && exp_q.size() > 0; n++) @(posedge clk);
        chk("pixels left", exp_q.size(), 0);
        end_sim();
    end
endmodule
`default_nettype wire

// File: testbench/vk_src_model.sv
// video source model feeding background, cut, fill and mask
`timescale 1ns/100ps
`default_nettype none
module vk_src_model (
    input  wire logic            clk,  // pixel clock
    output var  vk_pkg::vk_vin_t vid   // pixel stream to keyer
);
    import vk_pkg::*;

    initial vid = '0;

    // one pixel per edge, valid held across a burst
    task automatic send(input logic s, input logic [9:0] b, c, f, m, input logic mp);
        vid <= '{1'b1, s, b, c, f, m, mp};
        @(posedge clk);
    endtask

    // released lines show the inverse so stale data can never pass for a pixel
    task automatic idle();
        vid <= '{1'b0, 1'b0, ~vid.bg, ~vid.cut, ~vid.fill, ~vid.mask, ~vid.mpat};
        // blanking outlasts the keyer pipeline, so a settings swap at the next
        // frame start cannot reach pixels of this frame still in flight
        repeat (12) @(posedge clk);
    endtask
endmodule
`default_nettype wire
